/* File: rtl/wdtc_pkg.sv */
// Package of the watchdog timer control block: register offset, control
// register layout, reset value and timing counts.
// Assumes a single 100 MHz pclk domain shared by every user of it.

package wdtc_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   // Byte address of the control and status register on APB.
   localparam logic [11:0] WDTC_CTRL_OFS = 12'h000;

   // Control and status register layout, bit 7 first.
   typedef struct packed {
      logic timeout_irq_flag;        // Bit 7.
      logic timeout_irq_enable;      // Bit 6.
      logic period_select_bit3;      // Bit 5.
      logic change_unlock_bit;       // Bit 4.
      logic system_reset_enable;     // Bit 3.
      logic [2:0] period_select_lo;  // Bits 2 to 0.
   } wdtc_ctrl_t;

   // Reset value; the reset enable comes up cleared.
   localparam wdtc_ctrl_t WDTC_CTRL_RST = 8'h00;

   // ==========================================================
   // Timing
   // ==========================================================
   // The unlock window lasts this many pclk cycles.
   localparam int WDTC_UNLOCK_CYCLES = 4;
   localparam logic [2:0] WDTC_UNLOCK_LOAD = 3'(WDTC_UNLOCK_CYCLES - 1);
   // Oscillator cycles of the shortest period, and the largest legal code.
   localparam int WDTC_BASE_OSC_CYCLES = 2048;
   localparam logic [3:0] WDTC_PERIOD_MAX = 4'h9;
   // Width of the oscillator cycle counter.
   localparam int WDTC_CNT_W = 21;

   // Gathers the four period select bits into one code.
   function automatic logic [3:0] wdtc_period_code(input wdtc_ctrl_t c);
      wdtc_period_code = {c.period_select_bit3, c.period_select_lo};
   endfunction

endpackage

/* File: rtl/wdtc_osc_sync.sv */
// Oscillator input synchroniser: turns the free-running watchdog
// oscillator into a one-cycle tick enable in the pclk domain.
// Assumes the oscillator runs far slower than pclk.

`timescale 1ns/1ns
`default_nettype none

module wdtc_osc_sync
(
   input wire logic pclk,     // System clock.
   input wire logic presetn,  // Asynchronous reset, active low.
   input wire logic osc_in,   // Watchdog oscillator, asynchronous.
   output logic tick          // One-cycle pulse per oscillator rise.
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic lvl_r;
   logic tick_r;

   // ==========================================================
   // Three-stage synchroniser and filtered level
   // ==========================================================
   // A change counts once the second and third stages agree.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         lvl_r <= 1'b0;
         tick_r <= 1'b0;
      end
      else
      begin
         s1_r <= osc_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
         begin
            lvl_r <= s3_r;
         end
         tick_r <= (s2_r == s3_r) && s3_r && !lvl_r;
      end
   end

   assign tick = tick_r;

   // A tick marks exactly one rise of the filtered level.
   property p_tick_rise;
      @(posedge pclk) disable iff (!presetn)
      tick_r |-> lvl_r && !$past(lvl_r);
   endproperty
   a_tick_rise: assert property (p_tick_rise)
      else $error("Tick without a rise of the oscillator level.");

endmodule

`default_nettype wire

/* File: rtl/wdtc_counter.sv */
// Watchdog time-out counter: counts oscillator ticks up to the selected
// period and pulses a time-out, restarting from zero.
// Assumes tick and restart are one-cycle pulses in the pclk domain.

`timescale 1ns/1ns
`default_nettype none

module wdtc_counter
   import wdtc_pkg::*;
#(
   parameter int BASE = WDTC_BASE_OSC_CYCLES  // Shortest period.
)
(
   input wire logic pclk,        // System clock.
   input wire logic presetn,     // Asynchronous reset, active low.
   input wire logic tick,        // Oscillator tick enable.
   input wire logic restart,     // Restart instruction pulse.
   input wire logic run,         // Watchdog not stopped.
   input wire logic [3:0] code,  // Period select code.
   output logic timeout          // One-cycle time-out pulse.
);

   logic [WDTC_CNT_W-1:0] cnt_r;
   logic [WDTC_CNT_W-1:0] lim;
   logic timeout_r;

   // Period in oscillator cycles doubles with each code step.
   assign lim = WDTC_CNT_W'(BASE) << code;

   // ==========================================================
   // Counter
   // ==========================================================
   // A shortened period beyond the count fires at the next tick.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= '0;
         timeout_r <= 1'b0;
      end
      else
      begin
         timeout_r <= 1'b0;
         if (restart || !run)
         begin
            cnt_r <= '0;
         end
         else if (tick)
         begin
            if (cnt_r >= lim - WDTC_CNT_W'(1))
            begin
               cnt_r <= '0;
               timeout_r <= 1'b1;
            end
            else
            begin
               cnt_r <= cnt_r + WDTC_CNT_W'(1);
            end
         end
      end
   end

   assign timeout = timeout_r;

   // A time-out always leaves the counter at zero.
   property p_wrap_zero;
      @(posedge pclk) disable iff (!presetn)
      timeout_r |-> cnt_r == '0;
   endproperty
   a_wrap_zero: assert property (p_wrap_zero)
      else $error("Counter not cleared on time-out.");

   // A restart clears the counter and suppresses a time-out.
   property p_restart_zero;
      @(posedge pclk) disable iff (!presetn)
      restart |=> cnt_r == '0 && !timeout_r;
   endproperty
   a_restart_zero: assert property (p_restart_zero)
      else $error("Restart did not clear the counter.");

endmodule

`default_nettype wire

/* File: rtl/wdtc_core.sv */
// Watchdog timer with its control and status register on APB.
// Assumes APB master on pclk; core signals are pclk-synchronous, with restart and vector executed as one-cycle pulses.
//
// Behaviour
// - Time-out in interrupt mode sets the interrupt flag, bit 7.
// - Executing the watchdog interrupt vector clears the flag.
// - Writing one to the flag clears it; zero leaves it.
// - Interrupt requested only while flag, enable and global enable set.
// - Reset and interrupt enables pick mode; programmed fuse forces reset.
// - Combined mode: vector execution clears interrupt enable and flag.
// - Combined mode: second time-out before service causes system reset.
// - Reset enable clear or period change only while unlocked.
// - Unlock bit clears itself four clock cycles after being set.
// - Reset-cause flag holds reset enable at one.
// - Period codes 0 to 9 give 2048 to 1048576 oscillator cycles.
// - Eight-bit register layout; all bits reset to zero.
// - Counter counts cycles of the dedicated 128 kHz oscillator.
//
// Local design decisions: register access over APB and the register addresses.

`timescale 1ns/1ns
`default_nettype none

module wdtc_core
   import wdtc_pkg::*;
#(
   parameter int BASE_OSC_CYCLES = WDTC_BASE_OSC_CYCLES  // Shortest period.
)
(
   input wire logic pclk,              // System clock, 100 MHz.
   input wire logic presetn,           // Asynchronous reset, active low.
   input wire logic psel,              // APB select.
   input wire logic penable,           // APB enable.
   input wire logic pwrite,            // APB direction, high for write.
   input wire logic [11:0] paddr,      // APB byte address.
   input wire logic [31:0] pwdata,     // APB write data.
   input wire logic [3:0] pstrb,       // APB write strobes.
   output logic [31:0] prdata,         // APB read data.
   output logic pready,                // APB ready.
   output logic pslverr,               // APB error, unmapped address.
   input wire logic osc_in,            // Watchdog oscillator pin.
   input wire logic wd_restart,        // Restart instruction pulse.
   input wire logic irq_ack,           // Watchdog vector executed pulse.
   input wire logic global_irq_enable, // Core global interrupt enable.
   input wire logic always_on_fuse_n,  // Low when the fuse is programmed.
   input wire logic reset_cause_flag,  // Watchdog reset-cause flag level.
   output logic timeout_irq,           // Interrupt request, level.
   output logic sys_reset              // System reset, one-cycle pulse.
);

   // ==========================================================
   // Declarations
   // ==========================================================
   logic flag_r;
   logic ie_r;
   logic re_r;
   logic unlock_r;
   logic [2:0] unlock_cnt_r;
   logic [3:0] period_r;
   logic irq_r;
   logic sys_reset_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic setup;
   logic hit;
   logic wr;
   logic acc;
   logic fuse_on;
   logic tick;
   logic timeout;
   logic run;
   logic unlock_start;
   logic rst_fire;
   wdtc_ctrl_t wd;
   wdtc_ctrl_t rd;

   // ==========================================================
   // APB decode
   // ==========================================================
   // Setup cycle prepares the answer; the access cycle commits it.
   assign setup = psel && !penable;
   assign hit = paddr == WDTC_CTRL_OFS;
   assign acc = psel && penable && pready_r;
   assign wr = acc && pwrite && hit && !pslverr_r && pstrb[0];
   assign wd = wdtc_ctrl_t'(pwdata[7:0]);

   // Register view as software reads it.
   assign rd = '{
      timeout_irq_flag: flag_r,
      timeout_irq_enable: ie_r,
      period_select_bit3: period_r[3],
      change_unlock_bit: unlock_r,
      system_reset_enable: re_r,
      period_select_lo: period_r[2:0]
   };

   // Ready is raised for the single access cycle after each setup.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end
      else
      begin
         pready_r <= setup;
         if (setup)
         begin
            pslverr_r <= !hit;
            prdata_r <= hit ? {24'h000000, rd} : 32'h00000000;
         end
         else
         begin
            pslverr_r <= 1'b0;
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // ==========================================================
   // Mode selection
   // ==========================================================
   // The fuse forces reset mode; otherwise the enables pick it.
   assign fuse_on = !always_on_fuse_n;
   assign run = fuse_on || re_r || ie_r;
   assign unlock_start = wr && wd.change_unlock_bit && wd.system_reset_enable;
   // Reset mode, or combined mode with an unserviced interrupt.
   assign rst_fire = timeout && re_r && (!ie_r || flag_r);

   // ==========================================================
   // Oscillator tick and counter
   // ==========================================================
   // The oscillator is sampled into pclk, so restart and time-out stay
   // in one domain and need no further crossing.
   wdtc_osc_sync u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .osc_in(osc_in),
      .tick(tick)
   );

   wdtc_counter #(.BASE(BASE_OSC_CYCLES)) u_counter
   (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .restart(wd_restart),
      .run(run),
      .code(period_r),
      .timeout(timeout)
   );

   // ==========================================================
   // Unlock window
   // ==========================================================
   // Writing unlock and reset enable together opens a four-cycle window.
   // A write with the unlock bit clear closes it after being applied.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unlock_r <= 1'b0;
         unlock_cnt_r <= 3'h0;
      end
      else if (unlock_start)
      begin
         unlock_r <= 1'b1;
         unlock_cnt_r <= WDTC_UNLOCK_LOAD;
      end
      else if (wr && !wd.change_unlock_bit)
      begin
         unlock_r <= 1'b0;
      end
      else if (unlock_r)
      begin
         if (unlock_cnt_r == 3'h0)
         begin
            unlock_r <= 1'b0;
         end
         else
         begin
            unlock_cnt_r <= unlock_cnt_r - 3'h1;
         end
      end
   end

   // ==========================================================
   // Reset enable
   // ==========================================================
   // Setting is always allowed; clearing needs the unlock window and a
   // cleared reset-cause flag. The fuse pins it high.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         re_r <= WDTC_CTRL_RST.system_reset_enable;
      end
      else if (fuse_on || reset_cause_flag)
      begin
         re_r <= 1'b1;
      end
      else if (wr)
      begin
         if (wd.system_reset_enable)
         begin
            re_r <= 1'b1;
         end
         else if (unlock_r)
         begin
            re_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Period select
   // ==========================================================
   // Changed only inside the unlock window; reserved codes are dropped.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         period_r <= wdtc_period_code(WDTC_CTRL_RST);
      end
      else if (wr && unlock_r
               && wdtc_period_code(wd) <= WDTC_PERIOD_MAX)
      begin
         period_r <= wdtc_period_code(wd);
      end
   end

   // ==========================================================
   // Interrupt enable
   // ==========================================================
   // Vector execution in combined mode drops back to reset mode; a
   // software write in the same cycle takes precedence.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ie_r <= WDTC_CTRL_RST.timeout_irq_enable;
      end
      else if (fuse_on)
      begin
         ie_r <= 1'b0;
      end
      else if (wr)
      begin
         ie_r <= wd.timeout_irq_enable;
      end
      else if (irq_ack && re_r && ie_r)
      begin
         ie_r <= 1'b0;
      end
   end

   // ==========================================================
   // Interrupt flag
   // ==========================================================
   // A time-out setting the flag wins over any clear in that cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_r <= WDTC_CTRL_RST.timeout_irq_flag;
      end
      else if (timeout && ie_r)
      begin
         flag_r <= 1'b1;
      end
      else if (irq_ack)
      begin
         flag_r <= 1'b0;
      end
      else if (wr && wd.timeout_irq_flag)
      begin
         flag_r <= 1'b0;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // Interrupt request and one-cycle system reset pulse.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_r <= 1'b0;
         sys_reset_r <= 1'b0;
      end
      else
      begin
         irq_r <= flag_r && ie_r && global_irq_enable;
         sys_reset_r <= rst_fire;
      end
   end

   assign timeout_irq = irq_r;
   assign sys_reset = sys_reset_r;

   // ==========================================================
   // Assertions
   // ==========================================================
   // Time-out with the interrupt enabled sets the flag.
   property p_flag_set;
      @(posedge pclk) disable iff (!presetn)
      timeout && ie_r |=> flag_r;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("Time-out did not set the interrupt flag.");

   // Vector execution clears the flag when no time-out competes.
   property p_ack_clear;
      @(posedge pclk) disable iff (!presetn)
      irq_ack && !(timeout && ie_r) |=> !flag_r;
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("Vector execution did not clear the flag.");

   // Writing one clears the flag; writing zero keeps it.
   property p_w1c;
      @(posedge pclk) disable iff (!presetn)
      wr && !timeout && !irq_ack |=>
         flag_r == ($past(flag_r) && !$past(wd.timeout_irq_flag));
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("Flag write did not act as write-one-to-clear.");

   // Request follows flag, enable and global enable one cycle later.
   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      ##1 timeout_irq ==
         ($past(flag_r) && $past(ie_r) && $past(global_irq_enable));
   endproperty
   a_irq: assert property (p_irq)
      else $error("Interrupt request disagrees with its enables.");

   // A programmed fuse locks reset enable high and interrupt enable low.
   property p_fuse;
      @(posedge pclk) disable iff (!presetn)
      fuse_on && $past(presetn) |=> re_r && !ie_r;
   endproperty
   a_fuse: assert property (p_fuse)
      else $error("Programmed fuse did not force reset mode.");

   // Combined mode vector execution leaves plain reset mode.
   property p_combined_ack;
      @(posedge pclk) disable iff (!presetn)
      irq_ack && re_r && ie_r && !wr && !timeout |=>
         !ie_r && !flag_r && re_r;
   endproperty
   a_combined_ack: assert property (p_combined_ack)
      else $error("Combined mode did not fall back to reset mode.");

   // A second time-out with the flag pending resets the system.
   property p_second_timeout;
      @(posedge pclk) disable iff (!presetn)
      timeout && re_r && ie_r && flag_r |=> sys_reset;
   endproperty
   a_second_timeout: assert property (p_second_timeout)
      else $error("Second time-out gave no system reset.");

   // Outside the window the reset enable and period cannot be lowered.
   property p_locked;
      @(posedge pclk) disable iff (!presetn)
      !unlock_r && re_r |=> re_r && $stable(period_r);
   endproperty
   a_locked: assert property (p_locked)
      else $error("Locked setting changed outside the window.");

   // An undisturbed window closes exactly four cycles after opening.
   sequence s_unlock_open;
      $rose(unlock_r) ##1 !wr [*3];
   endsequence
   property p_unlock_close;
      @(posedge pclk) disable iff (!presetn)
      s_unlock_open |=> !unlock_r;
   endproperty
   a_unlock_close: assert property (p_unlock_close)
      else $error("Unlock window did not close after four cycles.");

   // The reset-cause flag holds the reset enable set.
   property p_cause;
      @(posedge pclk) disable iff (!presetn)
      reset_cause_flag && $past(presetn) |=> re_r;
   endproperty
   a_cause: assert property (p_cause)
      else $error("Reset enable cleared while reset cause is set.");

endmodule

`default_nettype wire

/* File: bench/wdtc_core_test.sv */
// Self-checking testbench of the watchdog timer control block.
// Assumes the package and design files are compiled before this file.
`timescale 1ns/1ns
`default_nettype none

module wdtc_core_test
   import wdtc_pkg::*;
;
   // ==========================================================
   // Signals and the design
   // ==========================================================
   localparam int BASE = 4;
   localparam int OSC = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic timeout_irq;
   logic sys_reset;
   logic osc_in = 1'b0;
   logic wd_restart = 1'b0;
   logic irq_ack = 1'b0;
   logic gie = 1'b0;
   logic fuse_n = 1'b1;
   logic rcf = 1'b0;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   int osc_div = 0;
   int n;
   logic [31:0] rd;
   logic err;

   wdtc_core #(.BASE_OSC_CYCLES(BASE)) i_dut
   (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .osc_in(osc_in),
      .wd_restart(wd_restart),
      .irq_ack(irq_ack),
      .global_irq_enable(gie),
      .always_on_fuse_n(fuse_n),
      .reset_cause_flag(rcf),
      .timeout_irq(timeout_irq),
      .sys_reset(sys_reset)
   );

   // Makes the 100 MHz system clock.
   initial
   begin
      forever #5 pclk = ~pclk;
   end

   // Makes the watchdog oscillator, OSC pclk periods long, on pclk edges.
   always @(posedge pclk)
   begin
      osc_div <= (osc_div == OSC/2 - 1) ? 0 : osc_div + 1;
      if (osc_div == OSC/2 - 1)
         osc_in <= ~osc_in;
   end

   // Cuts a hang short well after the expected run length.
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_mismatch = n_mismatch + 1;
         final_report();
      end
   end

   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask

   // One APB transfer; leaves a idle cycle so requests never collide.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] d);
      apb(1'b1, WDTC_CTRL_OFS, d);
   endtask

   task automatic rd_chk(input logic [7:0] exp);
      apb(1'b0, WDTC_CTRL_OFS, 8'h00);
      cmp8(rd[7:0], exp);
   endtask

   task automatic pulse(input logic ack);
      if (ack)
         irq_ack <= 1'b1;
      else
         wd_restart <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      wd_restart <= 1'b0;
      @(posedge pclk);
   endtask

   // Counts cycles until the chosen output is seen high, bounded.
   task automatic wait_for(input logic rst);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (((rst ? sys_reset : timeout_irq) !== 1'b1) && n < 3000);
   endtask

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_regs();
      rd_chk(8'h00);
      apb(1'b1, 12'h004, 8'h40);
      cmp1(err, 1'b1);
      rd_chk(8'h00);
      $display("register test done");
   endtask

   task automatic t_irq();
      gie <= 1'b1;
      wr(8'h18);
      wr(8'h41);
      pulse(1'b0);
      wait_for(1'b0);
      cmp1(n >= (2*BASE-1)*OSC && n <= 2*BASE*OSC+10, 1'b1);
      rd_chk(8'hC1);
      wr(8'h41);
      rd_chk(8'hC1);
      wr(8'hC1);
      rd_chk(8'h41);
      gie <= 1'b0;
      repeat (2*BASE*OSC+20) @(posedge pclk);
      cmp1(timeout_irq, 1'b0);
      rd_chk(8'hC1);
      gie <= 1'b1;
      repeat (2) @(posedge pclk);
      cmp1(timeout_irq, 1'b1);
      pulse(1'b1);
      @(posedge pclk);
      cmp1(timeout_irq, 1'b0);
      rd_chk(8'h41);
      gie <= 1'b0;
      $display("interrupt test done");
   endtask

   task automatic t_comb();
      gie <= 1'b1;
      wr(8'h48);
      pulse(1'b0);
      wait_for(1'b0);
      cmp1(sys_reset, 1'b0);
      wait_for(1'b1);
      cmp1(n >= (BASE-1)*OSC && n <= BASE*OSC+10, 1'b1);
      pulse(1'b1);
      rd_chk(8'h08);
      wait_for(1'b1);
      cmp1(n < 3000 && timeout_irq === 1'b0, 1'b1);
      wr(8'h48);
      wait_for(1'b0);
      cmp1(n < 3000 && sys_reset === 1'b0, 1'b1);
      gie <= 1'b0;
      fuse_n <= 1'b0;
      do_reset();
      wr(8'h40);
      rd_chk(8'h08);
      fuse_n <= 1'b1;
      $display("combined mode test done");
   endtask

   task automatic t_lock();
      wr(8'h08);
      wr(8'h00);
      rd_chk(8'h08);
      wr(8'h18);
      rd_chk(8'h18);
      rd_chk(8'h08);
      wr(8'h00);
      rd_chk(8'h08);
      wr(8'h18);
      wr(8'h2A);
      rd_chk(8'h08);
      rcf <= 1'b1;
      wr(8'h18);
      wr(8'h00);
      rd_chk(8'h08);
      rcf <= 1'b0;
      pulse(1'b0);
      wr(8'h18);
      wr(8'h01);
      rd_chk(8'h01);
      $display("unlock test done");
   endtask

   // Runs every scenario, t_irq straight after t_regs and the others each from a fresh reset, then reports.
   initial
   begin
      do_reset();
      t_regs();
      t_irq();
      do_reset();
      t_comb();
      do_reset();
      t_lock();
      final_report();
   end
endmodule

`default_nettype wire
